/* File: hdl/coss_top.sv */
`timescale 1ns/1ns
// Functional notes
// [R01] Reduced-swing mode comes from the upper three select fuses: 100..111 give the four ranges.
// [R02] Code 100 is meant for ceramic resonators only; the system integrator must not fit a quartz.
// [R03] Start-up count and added reset delay come from the low select bit and two start-up fuses.
// [R04] Select 0 with 00 waits 258 cycles, with 11 waits 1K, each adding 14 cycles plus 4 ms.
// [R05] Select 0 with 01 waits 258 cycles, select 1 with 00 waits 1K, each adding 14 plus 65 ms.
// [R06] Select 0 with 10 waits 1K cycles and adds only 14 cycles, no time-out.
// [R07] Select 1 with 01 waits 16K cycles and adds only 14 cycles.
// [R08] Select 1 with 10 waits 16K cycles and adds 14 cycles plus 4 ms.
// [R09] Select 1 with 11 waits 16K cycles and adds 14 cycles plus 65 ms.
// [R10] Upper select code 011 runs the full-swing oscillator for 0.4 to 20 MHz.
// [R11] Full-swing uses the same map but its fast-rising time-out is 4.1 ms.
// [R12] A programmed divide-by-eight fuse divides the clock by 8.
// [R13] The integrator picks 258-cycle settings only away from top speed and never with crystals.
// [R14] The added time-out is timed by watchdog oscillator ticks.
// [R15] Internal reset is held while the oscillator cycle count runs and released when done.
// [R16] A fuse reads 1 when unprogrammed and 0 when programmed; codes decode on that basis.
// [R17] Wake from sleep applies only the start-up count; 14 cycles and time-out only after reset.
module coss_top
#(
   parameter int SU_16K_CYC = coss_pkg::SU_16K_CYC,
   parameter int TOUT_LONG_TICKS = coss_pkg::TOUT_LONG_TICKS
)
(
   input wire logic CLK_SYS_IN,
   input wire logic RESETN_IN,
   input wire logic [coss_pkg::CLK_SEL_W-1:0] CLOCK_SOURCE_SELECT_FUSES_IN,
   input wire logic [coss_pkg::STARTUP_W-1:0] STARTUP_TIME_FUSES_IN,
   input wire logic DIVIDE_BY_EIGHT_FUSE_IN,
   input wire logic WDT_TICK_IN,
   input wire logic WAKE_IN,
   input wire logic PSEL_IN,
   input wire logic PENABLE_IN,
   input wire logic PWRITE_IN,
   input wire logic [coss_pkg::ADDR_W-1:0] PADDR_IN,
   input wire logic [31:0] PWDATA_IN,
   output logic [31:0] PRDATA_OUT,
   output logic PREADY_OUT,
   output logic PSLVERR_OUT,
   output logic INT_RESETN_OUT,
   output logic CLK_STABLE_OUT,
   output logic SLEEP_OUT,
   output logic FULL_SWING_OUT,
   output logic [2:0] FREQ_MODE_OUT,
   output logic SYS_CLK_EN_OUT
);

   // ****************************************
   // Elaboration checks
   // ****************************************
   if (SU_16K_CYC < 1 || SU_16K_CYC >= 2**coss_pkg::CNT_W)
      $error("SU_16K_CYC does not fit the counter");
   if (TOUT_LONG_TICKS < 1 || TOUT_LONG_TICKS >= 2**coss_pkg::CNT_W)
      $error("TOUT_LONG_TICKS does not fit the counter");

   localparam logic [coss_pkg::CNT_W-1:0] SU_16K = SU_16K_CYC[coss_pkg::CNT_W-1:0];
   localparam logic [coss_pkg::CNT_W-1:0] TOUT_LONG = TOUT_LONG_TICKS[coss_pkg::CNT_W-1:0];
   localparam logic [coss_pkg::CNT_W-1:0] TOUT_SHORT =
      coss_pkg::TOUT_SHORT_TICKS[coss_pkg::CNT_W-1:0];
   localparam logic [coss_pkg::CNT_W-1:0] TOUT_SHORT_FS =
      coss_pkg::TOUT_SHORT_FS_TICKS[coss_pkg::CNT_W-1:0];

   // ****************************************
   // Fuse decode
   // ****************************************
   function automatic logic [coss_pkg::CNT_W-1:0] startup_cycles(input logic sel0,
      input logic [1:0] su_code);
      logic [2:0] code;
      code = {sel0, su_code};
      case (code)
         3'h0, 3'h1: startup_cycles = coss_pkg::SU_258_CYC; // [R04] [R05]
         3'h2, 3'h3, 3'h4: startup_cycles = coss_pkg::SU_1K_CYC; // [R04] [R05] [R06]
         default: startup_cycles = SU_16K; // [R07] [R08] [R09]
      endcase
   endfunction

   function automatic coss_pkg::coss_tout_type timeout_sel(input logic sel0,
      input logic [1:0] su_code);
      logic [2:0] code;
      code = {sel0, su_code};
      case (code)
         3'h0, 3'h3, 3'h6: timeout_sel = coss_pkg::TOUT_SHORT; // [R04] [R08]
         3'h1, 3'h4, 3'h7: timeout_sel = coss_pkg::TOUT_LONG; // [R05] [R09]
         default: timeout_sel = coss_pkg::TOUT_NONE; // [R06] [R07]
      endcase
   endfunction

   logic [coss_pkg::CLK_SEL_W-1:0] clk_sel_r;
   logic [1:0] startup_r;
   logic div8_r;

   // Fuses are sensed while reset is held and stay frozen afterwards
   always_ff @(posedge CLK_SYS_IN)
   begin
      if (!RESETN_IN)
      begin
         clk_sel_r <= CLOCK_SOURCE_SELECT_FUSES_IN; // [R16]
         startup_r <= STARTUP_TIME_FUSES_IN;
         div8_r <= DIVIDE_BY_EIGHT_FUSE_IN;
      end
   end

   logic [2:0] mode;
   logic full_swing;
   logic mode_ok;
   coss_pkg::coss_tout_type tout_sel;
   logic [coss_pkg::CNT_W-1:0] su_cnt;
   logic [coss_pkg::CNT_W-1:0] tout_cnt;

   always_comb
   begin
      mode = clk_sel_r[coss_pkg::CLK_SEL_W-1:1]; // [R01]
      full_swing = (mode == coss_pkg::MODE_FULL_SWING); // [R10]
      mode_ok = full_swing || (mode >= coss_pkg::MODE_RS_0P4_0P9 &&
         mode <= coss_pkg::MODE_RS_8P0_16P0); // [R01]
      tout_sel = timeout_sel(clk_sel_r[0], startup_r); // [R03]
      su_cnt = startup_cycles(clk_sel_r[0], startup_r); // [R03]
      case (tout_sel)
         coss_pkg::TOUT_SHORT: tout_cnt = full_swing ? TOUT_SHORT_FS : TOUT_SHORT; // [R11]
         coss_pkg::TOUT_LONG: tout_cnt = TOUT_LONG;
         default: tout_cnt = coss_pkg::CNT_ONE;
      endcase
   end

   // ****************************************
   // APB slave
   // ****************************************
   logic pready_r;
   logic [31:0] prdata_r;
   logic pslverr_r;
   logic apb_write;
   logic addr_ok;
   logic sleep_req;
   logic [31:0] status_word;
   logic [31:0] fuse_word;
   coss_pkg::coss_state_type state_r;
   coss_pkg::coss_state_type state_nxt;

   always_comb
   begin
      addr_ok = (PADDR_IN == coss_pkg::OFF_CTRL) || (PADDR_IN == coss_pkg::OFF_STATUS) ||
         (PADDR_IN == coss_pkg::OFF_FUSE);
      apb_write = PSEL_IN && PENABLE_IN && pready_r && PWRITE_IN;
      sleep_req = apb_write && (PADDR_IN == coss_pkg::OFF_CTRL) &&
         PWDATA_IN[coss_pkg::CTRL_SLEEP_BIT];
      status_word = '0;
      status_word[coss_pkg::ST_STATE_LSB +: 3] = state_r;
      status_word[coss_pkg::ST_RESETN_BIT] = INT_RESETN_OUT;
      status_word[coss_pkg::ST_STABLE_BIT] = CLK_STABLE_OUT;
      status_word[coss_pkg::ST_MODE_OK_BIT] = mode_ok;
      status_word[coss_pkg::ST_FULL_BIT] = full_swing;
      status_word[coss_pkg::ST_TOUT_LSB +: 2] = tout_sel;
      status_word[coss_pkg::ST_DIV8_BIT] = (div8_r == coss_pkg::DIV8_PROGRAMMED);
      fuse_word = '0;
      fuse_word[coss_pkg::CLK_SEL_W-1:0] = clk_sel_r;
      fuse_word[coss_pkg::FUSE_STARTUP_LSB +: 2] = startup_r;
      fuse_word[coss_pkg::FUSE_DIV8_BIT] = div8_r;
   end

   // No wait state: ready rises in the first access cycle
   always_ff @(posedge CLK_SYS_IN)
   begin
      if (!RESETN_IN)
      begin
         pready_r <= 1'b0;
         prdata_r <= '0;
         pslverr_r <= 1'b0;
      end
      else
      begin
         pready_r <= PSEL_IN && !PENABLE_IN;
         pslverr_r <= PSEL_IN && !PENABLE_IN && !addr_ok;
         if (PSEL_IN && !PENABLE_IN && !PWRITE_IN)
         begin
            case (PADDR_IN)
               coss_pkg::OFF_STATUS: prdata_r <= status_word;
               coss_pkg::OFF_FUSE: prdata_r <= fuse_word;
               default: prdata_r <= '0;
            endcase
         end
      end
   end

   // ****************************************
   // Start-up sequencer
   // ****************************************
   logic [coss_pkg::CNT_W-1:0] cnt_r;
   logic [coss_pkg::CNT_W-1:0] cnt_nxt;
   logic cnt_last;

   always_comb
   begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      cnt_last = (cnt_r == coss_pkg::CNT_ONE);
      case (state_r)
         coss_pkg::ST_HOLD:
         begin
            if (tout_sel == coss_pkg::TOUT_NONE)
            begin
               state_nxt = coss_pkg::ST_STARTUP;
               cnt_nxt = su_cnt;
            end
            else
            begin
               state_nxt = coss_pkg::ST_TIMEOUT;
               cnt_nxt = tout_cnt;
            end
         end
         coss_pkg::ST_TIMEOUT:
         begin
            if (WDT_TICK_IN) // [R14]
            begin
               if (cnt_last)
               begin
                  state_nxt = coss_pkg::ST_STARTUP;
                  cnt_nxt = su_cnt;
               end
               else
                  cnt_nxt = cnt_r - coss_pkg::CNT_ONE;
            end
         end
         coss_pkg::ST_STARTUP:
         begin
            if (cnt_last) // [R15]
            begin
               state_nxt = coss_pkg::ST_DELAY;
               cnt_nxt = coss_pkg::RESET_DELAY_CYC;
            end
            else
               cnt_nxt = cnt_r - coss_pkg::CNT_ONE;
         end
         coss_pkg::ST_DELAY:
         begin
            if (cnt_last)
               state_nxt = coss_pkg::ST_RUN;
            else
               cnt_nxt = cnt_r - coss_pkg::CNT_ONE;
         end
         coss_pkg::ST_RUN:
         begin
            if (sleep_req)
               state_nxt = coss_pkg::ST_SLEEP;
         end
         coss_pkg::ST_SLEEP:
         begin
            if (WAKE_IN)
            begin
               state_nxt = coss_pkg::ST_WAKE;
               cnt_nxt = su_cnt; // [R17]
            end
         end
         coss_pkg::ST_WAKE:
         begin
            // Supply is assumed good here, so no time-out and no extra delay
            if (cnt_last)
               state_nxt = coss_pkg::ST_RUN; // [R17]
            else
               cnt_nxt = cnt_r - coss_pkg::CNT_ONE;
         end
         default:
            state_nxt = coss_pkg::ST_HOLD;
      endcase
   end

   always_ff @(posedge CLK_SYS_IN)
   begin
      if (!RESETN_IN)
      begin
         state_r <= coss_pkg::ST_HOLD;
         cnt_r <= '0;
      end
      else
      begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   // ****************************************
   // Registered outputs
   // ****************************************
   logic int_resetn_r;
   logic clk_stable_r;
   logic sleep_r;
   logic full_swing_r;
   logic [2:0] freq_mode_r;

   always_ff @(posedge CLK_SYS_IN)
   begin
      if (!RESETN_IN)
      begin
         int_resetn_r <= 1'b0;
         clk_stable_r <= 1'b0;
         sleep_r <= 1'b0;
         full_swing_r <= 1'b0;
         freq_mode_r <= '0;
      end
      else
      begin
         // Internal reset stays low until the first pass reaches run
         int_resetn_r <= (state_nxt == coss_pkg::ST_RUN) || (state_nxt == coss_pkg::ST_SLEEP) ||
            (state_nxt == coss_pkg::ST_WAKE); // [R15]
         clk_stable_r <= (state_nxt == coss_pkg::ST_RUN);
         sleep_r <= (state_nxt == coss_pkg::ST_SLEEP);
         full_swing_r <= full_swing; // [R10]
         freq_mode_r <= mode_ok ? mode : '0; // [R01]
      end
   end

   // Clock enable every cycle, or one in eight when the divider fuse is programmed
   logic [2:0] div_cnt_r;
   logic sys_clk_en_r;

   always_ff @(posedge CLK_SYS_IN)
   begin
      if (!RESETN_IN)
      begin
         div_cnt_r <= '0;
         sys_clk_en_r <= 1'b0;
      end
      else
      begin
         div_cnt_r <= div_cnt_r + 3'h1;
         if (div8_r == coss_pkg::DIV8_PROGRAMMED)
            sys_clk_en_r <= (div_cnt_r == coss_pkg::DIV8_LAST); // [R12]
         else
            sys_clk_en_r <= 1'b1;
      end
   end

   assign PREADY_OUT = pready_r;
   assign PRDATA_OUT = prdata_r;
   assign PSLVERR_OUT = pslverr_r;
   assign INT_RESETN_OUT = int_resetn_r;
   assign CLK_STABLE_OUT = clk_stable_r;
   assign SLEEP_OUT = sleep_r;
   assign FULL_SWING_OUT = full_swing_r;
   assign FREQ_MODE_OUT = freq_mode_r;
   assign SYS_CLK_EN_OUT = sys_clk_en_r;

endmodule // coss_top

/* File: hdl/coss_pkg.sv */
package coss_pkg;

   // ****************************************
   // Fuse layout (1 = unprogrammed, 0 = programmed)
   // ****************************************
   localparam int CLK_SEL_W = 4;
   localparam int STARTUP_W = 2;
   localparam logic [2:0] MODE_FULL_SWING = 3'h3;
   localparam logic [2:0] MODE_RS_0P4_0P9 = 3'h4;
   localparam logic [2:0] MODE_RS_0P9_3P0 = 3'h5;
   localparam logic [2:0] MODE_RS_3P0_8P0 = 3'h6;
   localparam logic [2:0] MODE_RS_8P0_16P0 = 3'h7;
   localparam logic DIV8_PROGRAMMED = 1'h0;

   // ****************************************
   // Start-up counts in oscillator cycles
   // ****************************************
   localparam int CNT_W = 16;
   localparam logic [CNT_W-1:0] SU_258_CYC = 16'h0102;
   localparam logic [CNT_W-1:0] SU_1K_CYC = 16'h0400;
   localparam int SU_16K_CYC = 16384;
   localparam logic [CNT_W-1:0] RESET_DELAY_CYC = 16'h000E;
   localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;

   // ****************************************
   // Time-outs, counted in watchdog oscillator ticks
   // ****************************************
   localparam longint WDT_FREQ_HZ = 128000;
   localparam longint US_PER_S = 1000000;
   localparam longint TOUT_SHORT_US = 4000;
   localparam longint TOUT_SHORT_FS_US = 4100;
   localparam longint TOUT_LONG_US = 65000;
   // Least times: round up to whole ticks
   localparam int TOUT_SHORT_TICKS = int'((TOUT_SHORT_US * WDT_FREQ_HZ + US_PER_S - 1) / US_PER_S);
   localparam int TOUT_SHORT_FS_TICKS =
      int'((TOUT_SHORT_FS_US * WDT_FREQ_HZ + US_PER_S - 1) / US_PER_S);
   localparam int TOUT_LONG_TICKS = int'((TOUT_LONG_US * WDT_FREQ_HZ + US_PER_S - 1) / US_PER_S);

   // ****************************************
   // APB register map
   // ****************************************
   localparam int ADDR_W = 12;
   localparam logic [ADDR_W-1:0] OFF_CTRL = 12'h000;
   localparam logic [ADDR_W-1:0] OFF_STATUS = 12'h004;
   localparam logic [ADDR_W-1:0] OFF_FUSE = 12'h008;
   localparam int CTRL_SLEEP_BIT = 0;
   localparam int ST_STATE_LSB = 0;
   localparam int ST_RESETN_BIT = 4;
   localparam int ST_STABLE_BIT = 5;
   localparam int ST_MODE_OK_BIT = 6;
   localparam int ST_FULL_BIT = 7;
   localparam int ST_TOUT_LSB = 8;
   localparam int ST_DIV8_BIT = 10;
   localparam int FUSE_STARTUP_LSB = 4;
   localparam int FUSE_DIV8_BIT = 6;
   localparam logic [2:0] DIV8_LAST = 3'h7;

   typedef enum logic [2:0] {ST_HOLD, ST_TIMEOUT, ST_STARTUP, ST_DELAY, ST_RUN, ST_SLEEP,
      ST_WAKE} coss_state_type;
   typedef enum logic [1:0] {TOUT_NONE, TOUT_SHORT, TOUT_LONG} coss_tout_type;

endpackage

/* File: verification/coss_chk.sv */
`timescale 1ns/1ns
module coss_chk
(
   input wire logic CLK_SYS_IN,
   input wire logic RESETN_IN,
   input wire logic PSEL_IN,
   input wire logic PENABLE_IN,
   input wire logic [11:0] PADDR_IN,
   input wire logic PREADY_OUT,
   input wire logic PSLVERR_OUT,
   input wire logic INT_RESETN_OUT,
   input wire logic CLK_STABLE_OUT,
   input wire logic SLEEP_OUT,
   input wire logic FULL_SWING_OUT,
   input wire logic [2:0] FREQ_MODE_OUT,
   input wire logic SYS_CLK_EN_OUT
);
   // ****************************************
   // Properties
   // ****************************************
   default clocking cb @(posedge CLK_SYS_IN);
   endclocking
   default disable iff (!RESETN_IN);

   a_reset_holds_low: assert property (disable iff (1'b0) !RESETN_IN |=>
      !INT_RESETN_OUT && !CLK_STABLE_OUT && !SLEEP_OUT && !PREADY_OUT)
      else $error("outputs not cleared in reset");
   a_ready_one_access: assert property (PSEL_IN && !PENABLE_IN |=> PREADY_OUT ##1 !PREADY_OUT)
      else $error("ready not a single access pulse");
   a_unmapped_error: assert property (PSEL_IN && !PENABLE_IN && !(PADDR_IN inside
      {12'h000, 12'h004, 12'h008}) |=> PSLVERR_OUT && PREADY_OUT)
      else $error("unmapped access without error");
   a_stable_in_reset: assert property (CLK_STABLE_OUT |-> INT_RESETN_OUT)
      else $error("clock stable while internal reset held");
   a_release_stays: assert property (INT_RESETN_OUT |=> INT_RESETN_OUT)
      else $error("internal reset fell without external reset");
   a_full_swing_mode: assert property (FULL_SWING_OUT |-> FREQ_MODE_OUT == 3'h3)
      else $error("full swing with wrong mode");
   a_sleep_no_stable: assert property (SLEEP_OUT |-> !CLK_STABLE_OUT && INT_RESETN_OUT)
      else $error("sleep state outputs inconsistent");
   a_div8_period: assert property ($fell(SYS_CLK_EN_OUT) |-> (!SYS_CLK_EN_OUT)[*7]
      ##1 SYS_CLK_EN_OUT)
      else $error("divided clock enable period not 8");
   a_mode_range: assert property (FREQ_MODE_OUT != 3'h0 |-> FREQ_MODE_OUT >= 3'h3)
      else $error("frequency mode code out of range");
endmodule // coss_chk

bind coss_top coss_chk u_chk (.CLK_SYS_IN(CLK_SYS_IN), .RESETN_IN(RESETN_IN),
   .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN), .PADDR_IN(PADDR_IN), .PREADY_OUT(PREADY_OUT),
   .PSLVERR_OUT(PSLVERR_OUT), .INT_RESETN_OUT(INT_RESETN_OUT),
   .CLK_STABLE_OUT(CLK_STABLE_OUT), .SLEEP_OUT(SLEEP_OUT), .FULL_SWING_OUT(FULL_SWING_OUT),
   .FREQ_MODE_OUT(FREQ_MODE_OUT), .SYS_CLK_EN_OUT(SYS_CLK_EN_OUT));

/* File: verification/coss_top_bench.sv */
`timescale 1ns/1ns
module coss_top_bench;
   logic clk, rst_n, psel, penable, pwrite, div8, wake, e, tick, d8;
   logic pready, pslverr, int_rst_n, stable, sleep, full, clk_en;
   logic [3:0] sel;
   logic [1:0] su;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [2:0] mode, up;
   logic [15:0] rnd;
   int mismatches, num_checks, cyc, n, x, xt;

   // Long 16K and 65 ms counts shortened so a full sweep of codes stays quick
   coss_top #(.SU_16K_CYC(40), .TOUT_LONG_TICKS(20)) uut (.CLK_SYS_IN(clk), .RESETN_IN(rst_n),
      .CLOCK_SOURCE_SELECT_FUSES_IN(sel), .STARTUP_TIME_FUSES_IN(su),
      .DIVIDE_BY_EIGHT_FUSE_IN(div8), .WDT_TICK_IN(tick), .WAKE_IN(wake), .PSEL_IN(psel),
      .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
      .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
      .INT_RESETN_OUT(int_rst_n), .CLK_STABLE_OUT(stable), .SLEEP_OUT(sleep),
      .FULL_SWING_OUT(full), .FREQ_MODE_OUT(mode), .SYS_CLK_EN_OUT(clk_en));

   // ****************************************
   // Helpers
   // ****************************************
   function logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function int slen(input logic [2:0] c);
      return c < 2 ? 258 : (c < 5 ? 1024 : 40);
   endfunction
   // Time-out kind: 1 short, 2 long, 0 none
   function logic [1:0] tc(input logic [2:0] c);
      return (c % 3 == 0) ? 2'h1 : ((c % 3 == 1) ? 2'h2 : 2'h0);
   endfunction
   function int tlen(input logic [2:0] c, input logic fs);
      return tc(c) == 2'h1 ? (fs ? 525 : 512) : (tc(c) == 2'h2 ? 20 : 0);
   endfunction
   task test_done;
      $display("checks=%0d mismatches=%0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
         mismatches++;
      end
   endtask
   task automatic wait_hi(ref logic s);
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (s !== 1'b1 && n < 30000);
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      wait_hi(pready);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 60000)
      begin
         mismatches++;
         test_done;
      end
   end

   // ****************************************
   // Sweep of every start-up code
   // ****************************************
   initial
   begin
      rst_n = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; wake = 0; tick = 1;
      sel = 4'hF; su = 2'h3; div8 = 1; rnd = 16'hB98A; mismatches = 0; num_checks = 0; cyc = 0;
      repeat (10) @(posedge clk);
      for (int c = 0; c < 8; c++)
      begin
         rnd = lfsr(rnd);
         up = rnd[0] ? {1'b1, rnd[2:1]} : 3'h3;
         // Corners: a code outside both oscillator ranges, and full swing on a short time-out
         if (c == 2)
            up = 3'h1;
         if (c == 3)
            up = 3'h3;
         if (c >= 5 && up == 3'h4)
            up = 3'h5;
         if (c < 2 && up == 3'h7)
            up = 3'h6;
         d8 = rnd[3] && c != 4;
         xt = (tc(c[2:0]) != 2'h0) ? int'(rnd[7:4]) : 0;
         rst_n <= 1'b0;
         sel <= {up, c[2]};
         su <= c[1:0];
         div8 <= d8;
         repeat (2) @(posedge clk);
         rst_n <= 1'b1;
         tick <= 1'b0;
         // Watchdog ticks held off for a while: only the time-out may stretch
         fork
            begin
               repeat (1 + int'(rnd[7:4])) @(posedge clk);
               tick <= 1'b1;
            end
            wait_hi(int_rst_n);
         join
         chk(n, 16 + xt + tlen(c[2:0], up == 3'h3) + slen(c[2:0]));
         chk({stable, full, mode},
            {1'b1, up == 3'h3, (up[2] || up == 3'h3) ? up : 3'h0});
         x = 0;
         repeat (16)
         begin
            @(posedge clk);
            x += int'(clk_en);
         end
         chk(x, d8 ? 16 : 2);
         apb(1'b0, 12'h004, 32'h0000_0000);
         chk({q[10:4], q[2:0]},
            {~d8, tc(c[2:0]), up == 3'h3, up[2] || up == 3'h3, 2'h3, 3'h4});
         apb(1'b0, 12'h008, 32'h0000_0000);
         chk(q[6:0], {d8, c[1:0], up, c[2]});
         apb(1'b0, 12'h00C, 32'hFFFF_FFFF);
         chk({31'h0, e}, 32'h0000_0001);
         chk(q, 32'h0000_0000);
         apb(1'b1, 12'h000, 32'h0000_0001);
         @(posedge clk);
         chk({sleep, stable, int_rst_n}, 3'h5);
         repeat (5) @(posedge clk);
         wake <= 1'b1;
         wait_hi(stable);
         wake <= 1'b0;
         chk(n, slen(c[2:0]) + 2);
         chk({sleep, int_rst_n}, 2'h1);
      end
      test_done;
   end
endmodule // coss_top_bench
